// *** verilog/mao_pkg.sv ***
/*
  Package for the multiplier accumulator operations block: operation codes,
  field positions, format codes, widths and reset values.
  Assumes a single core clock and a synchronous active-low core reset.
*/
package mao_pkg;

  localparam int RF_WIDTH  = 40;
  localparam int FIX_WIDTH = 32;
  localparam int EXT_WIDTH = 8;
  localparam int ACC_WIDTH = 80;
  localparam int LOW_WIDTH = 32;
  localparam int MID_WIDTH = 32;
  localparam int HIGH_WIDTH = 16;
  localparam int RSEL_WIDTH = 4;

  // Operation codes presented by the instruction decoder.
  typedef enum logic [2:0] {
    MAO_OP_NONE  = 3'h0,
    MAO_OP_ROUND = 3'h1,
    MAO_OP_CLEAR = 3'h2,
    MAO_OP_MOVE  = 3'h3,
    MAO_OP_FMUL  = 3'h4
  } mao_op_t;

  // Move compute field layout.
  localparam int MV_DIR_POS  = 12;
  localparam int MV_SEL_LSB  = 8;
  localparam int MV_REG_LSB  = 4;
  localparam int MV_FIELD_W  = 23;

  // Accumulator part select codes.
  localparam logic [3:0] SEL_PRI_LOW  = 4'h0;
  localparam logic [3:0] SEL_PRI_MID  = 4'h1;
  localparam logic [3:0] SEL_PRI_HIGH = 4'h2;
  localparam logic [3:0] SEL_ALT_LOW  = 4'h4;
  localparam logic [3:0] SEL_ALT_MID  = 4'h5;
  localparam logic [3:0] SEL_ALT_HIGH = 4'h6;

  // Format modifier codes: bit 1 fractional, bit 0 signed.
  localparam logic [1:0] FMT_SI = 2'h1;
  localparam logic [1:0] FMT_UI = 2'h0;
  localparam logic [1:0] FMT_SF = 2'h3;
  localparam logic [1:0] FMT_UF = 2'h2;

  // Round point and bit counts for overflow and underflow.
  localparam int ROUND_POS   = 32;
  localparam int OVF_SF_BITS = 33;
  localparam int OVF_SI_BITS = 49;
  localparam int OVF_UF_BITS = 32;
  localparam int OVF_UI_BITS = 48;
  localparam int UNF_HI_BITS = 48;
  localparam int UNF_LO_BITS = 32;

  // Float exponent limits.
  localparam int EXP_BIAS = 127;
  localparam int EXP_MAX  = 127;
  localparam int EXP_MIN  = -126;

  localparam logic [ACC_WIDTH-1:0] ACC_RESET   = 80'h0;
  localparam logic [3:0]           FLAGS_RESET = 4'h0;

endpackage : mao_pkg

// *** verilog/mao_fmul.sv ***
/*
  Single-precision multiply on the 40-bit register format (sign, exponent,
  31-bit fraction with the low 8 bits of extension).
  Combinational; the caller registers the product and flags.
*/
`timescale 1ns/1ps
module mao_fmul
  import mao_pkg::*;
(
  input  wire logic [RF_WIDTH-1:0] a_i,
  input  wire logic [RF_WIDTH-1:0] b_i,
  output logic      [RF_WIDTH-1:0] prod_o,
  output logic                     neg_o,
  output logic                     ovf_o,
  output logic                     unf_o,
  output logic                     inv_o
);

  logic        sign;
  logic [7:0]  ea;
  logic [7:0]  eb;
  logic [31:0] ma;
  logic [31:0] mb;
  logic [63:0] mp;
  logic signed [10:0] eu;
  logic signed [10:0] er;
  logic        a_nan;
  logic        b_nan;
  logic        a_inf;
  logic        b_inf;
  logic        a_zero;
  logic        b_zero;
  logic [30:0] frac;

  always_comb begin
    sign   = a_i[39] ^ b_i[39];
    ea     = a_i[38:31];
    eb     = b_i[38:31];
    ma     = {1'b1, a_i[30:0]};
    mb     = {1'b1, b_i[30:0]};
    a_nan  = (ea == 8'hFF) && (a_i[30:0] != 31'h0);
    b_nan  = (eb == 8'hFF) && (b_i[30:0] != 31'h0);
    a_inf  = (ea == 8'hFF) && (a_i[30:0] == 31'h0);
    b_inf  = (eb == 8'hFF) && (b_i[30:0] == 31'h0);
    a_zero = (ea == 8'h00);
    b_zero = (eb == 8'h00);
    mp     = ma * mb;
    eu     = 11'($signed({3'h0, ea})) + 11'($signed({3'h0, eb})) - 11'(2 * EXP_BIAS);
    if (mp[63]) begin
      er   = eu + 11'sd1;
      frac = mp[62:32];
    end else begin
      er   = eu;
      frac = mp[61:31];
    end
    inv_o = a_nan || b_nan || (a_inf && b_zero) || (b_inf && a_zero);
    neg_o = 1'b0;
    ovf_o = 1'b0;
    unf_o = 1'b0;
    if (inv_o) begin
      prod_o = {1'b0, 8'hFF, 31'h7FFFFFFF};
    end else if (a_inf || b_inf) begin
      prod_o = {sign, 8'hFF, 31'h0};
      neg_o  = sign;
    end else if (a_zero || b_zero) begin
      prod_o = {sign, 39'h0};
      neg_o  = sign;
    end else if (er > 11'(EXP_MAX)) begin
      ovf_o  = 1'b1;
      neg_o  = sign;
      prod_o = {sign, 8'hFF, 31'h0};
    end else if (er < 11'(EXP_MIN)) begin
      unf_o  = 1'b1;
      neg_o  = sign;
      prod_o = {sign, 39'h0};
    end else begin
      neg_o  = sign;
      prod_o = {sign, 8'(er + 11'(EXP_BIAS)), frac};
    end
  end

endmodule : mao_fmul

// *** verilog/mao_core.sv ***
/*
  Multiplier accumulator operations: round, clear, moves between accumulator
  words and the register file, and floating-point multiply, with the four
  multiplier status flags.
  Assumes the instruction decoder presents one operation per cycle with its
  operands already read from the register file; results appear next cycle.
*/
// Function
// - Round selected accumulator to nearest at bit 32.
// - Round written back to the same accumulator that supplied it.
// - Register result takes bits 31-0 integer, 63-32 fractional.
// - Accumulator words written to registers get a zero extension field.
// - Accumulator destination stores the full 80-bit round result.
// - Overflow when upper 33/49/32/48 bits not all zero (or all one, signed formats only).
// - Underflow on fractional result, upper 48 all zero (or all one if signed), lower 32 nonzero.
// - Round sets negative from sign and leaves invalid unchanged.
// - Clear zeroes all 80 bits and keeps all four flags.
// - Move into accumulator takes fixed-point field, ignores extension.
// - Move out places the word in the register fixed-point field.
// - Direction bit 0 moves to register file, 1 to accumulator.
// - Part select decodes low, middle, high for primary and alternate.
// - Register select field names the source or destination register.
// - Float multiply writes product and sets negative when negative.
// - Float overflow when unbiased exponent exceeds 127.
// - Float underflow when unbiased exponent is below -126.
// - Float invalid on any NaN input or infinity times zero.
// - Format modifier picks signed/unsigned and integer/fractional.
`timescale 1ns/1ps
module mao_core
  import mao_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  op_valid_i,
  input  wire mao_op_t               op_i,
  input  wire logic                  acc_alt_i,
  input  wire logic                  to_acc_i,
  input  wire logic [1:0]            format_modifier_i,
  input  wire logic [MV_FIELD_W-1:0] move_field_i,
  input  wire logic [RSEL_WIDTH-1:0] dest_data_reg_i,
  input  wire logic [RF_WIDTH-1:0]   opnd_x_i,
  input  wire logic [RF_WIDTH-1:0]   opnd_y_i,
  output logic                       rf_we_o,
  output logic      [RSEL_WIDTH-1:0] rf_waddr_o,
  output logic      [RF_WIDTH-1:0]   rf_wdata_o,
  output logic                       bad_select_o,
  output logic                       product_negative_flag_o,
  output logic                       product_overflow_flag_o,
  output logic                       product_underflow_flag_o,
  output logic                       product_invalid_flag_o,
  output logic      [ACC_WIDTH-1:0]  accum_primary_o,
  output logic      [ACC_WIDTH-1:0]  accum_alternate_o
);

  // Accumulator pieces, index 0 primary, 1 alternate.
  logic [LOW_WIDTH-1:0]  accum_low_word    [2];
  logic [MID_WIDTH-1:0]  accum_middle_word [2];
  logic [HIGH_WIDTH-1:0] accum_high_word   [2];

  logic                  sel_idx;
  logic [ACC_WIDTH-1:0]  acc_src;
  logic [ACC_WIDTH-1:0]  rnd_res;
  logic                  rnd_ovf;
  logic                  rnd_unf;
  logic                  mv_dir;
  logic [3:0]            accum_part_select;
  logic [RSEL_WIDTH-1:0] data_reg_select;
  logic                  sel_legal;
  logic                  sel_alt;
  logic [1:0]            sel_part;
  logic [RF_WIDTH-1:0]   fm_prod;
  logic                  fm_neg;
  logic                  fm_ovf;
  logic                  fm_unf;
  logic                  fm_inv;
  logic                  do_op;

  function automatic logic upper_bad(input logic [ACC_WIDTH-1:0] v, input int n,
                                     input logic sgn);
    logic all0;
    logic all1;
    all0 = 1'b1;
    all1 = 1'b1;
    for (int i = 0; i < ACC_WIDTH; i++) begin
      if (i >= ACC_WIDTH - n) begin
        all0 = all0 & ~v[i];
        all1 = all1 & v[i];
      end
    end
    upper_bad = !(all0 || (sgn && all1));
  endfunction : upper_bad

  function automatic logic [RF_WIDTH-1:0] to_rf(input logic [FIX_WIDTH-1:0] w);
    to_rf = {w, {EXT_WIDTH{1'b0}}};
  endfunction : to_rf

  assign do_op = op_valid_i;

  always_comb begin
    sel_idx = acc_alt_i;
    acc_src = {accum_high_word[sel_idx], accum_middle_word[sel_idx],
               accum_low_word[sel_idx]};
    rnd_res = acc_src + (ACC_WIDTH'(1) << (ROUND_POS - 1));
    rnd_res[ROUND_POS-1:0] = '0;
    // Overflow bit count by format.
    unique case (format_modifier_i)
      FMT_SF:  rnd_ovf = upper_bad(rnd_res, OVF_SF_BITS, 1'b1);
      FMT_SI:  rnd_ovf = upper_bad(rnd_res, OVF_SI_BITS, 1'b1);
      FMT_UF:  rnd_ovf = upper_bad(rnd_res, OVF_UF_BITS, 1'b0);
      FMT_UI:  rnd_ovf = upper_bad(rnd_res, OVF_UI_BITS, 1'b0);
    endcase
    rnd_unf = format_modifier_i[1]
              && !upper_bad(rnd_res, UNF_HI_BITS, format_modifier_i[0])
              && (rnd_res[UNF_LO_BITS-1:0] != '0);
  end

  always_comb begin
    mv_dir            = move_field_i[MV_DIR_POS];
    accum_part_select = move_field_i[MV_SEL_LSB +: 4];
    data_reg_select   = move_field_i[MV_REG_LSB +: RSEL_WIDTH];
    sel_legal = 1'b1;
    sel_alt   = 1'b0;
    sel_part  = 2'h0;
    unique case (accum_part_select)
      SEL_PRI_LOW:  sel_part = 2'h0;
      SEL_PRI_MID:  sel_part = 2'h1;
      SEL_PRI_HIGH: sel_part = 2'h2;
      SEL_ALT_LOW:  begin sel_alt = 1'b1; sel_part = 2'h0; end
      SEL_ALT_MID:  begin sel_alt = 1'b1; sel_part = 2'h1; end
      SEL_ALT_HIGH: begin sel_alt = 1'b1; sel_part = 2'h2; end
      default:      sel_legal = 1'b0;
    endcase
  end

  mao_fmul u_fmul (
    .a_i    (opnd_x_i),
    .b_i    (opnd_y_i),
    .prod_o (fm_prod),
    .neg_o  (fm_neg),
    .ovf_o  (fm_ovf),
    .unf_o  (fm_unf),
    .inv_o  (fm_inv)
  );

  // Accumulator updates.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < 2; k++) begin
        accum_low_word[k]    <= ACC_RESET[LOW_WIDTH-1:0];
        accum_middle_word[k] <= ACC_RESET[LOW_WIDTH+MID_WIDTH-1:LOW_WIDTH];
        accum_high_word[k]   <= ACC_RESET[ACC_WIDTH-1:LOW_WIDTH+MID_WIDTH];
      end
    end else if (do_op) begin
      unique case (op_i)
        MAO_OP_ROUND: begin
          if (to_acc_i) begin
            accum_low_word[sel_idx]    <= rnd_res[31:0];
            accum_middle_word[sel_idx] <= rnd_res[63:32];
            accum_high_word[sel_idx]   <= rnd_res[79:64];
          end
        end
        MAO_OP_CLEAR: begin
          accum_low_word[sel_idx]    <= '0;
          accum_middle_word[sel_idx] <= '0;
          accum_high_word[sel_idx]   <= '0;
        end
        MAO_OP_MOVE: begin
          if (mv_dir && sel_legal) begin
            unique case (sel_part)
              2'h0: accum_low_word[sel_alt]    <= opnd_x_i[RF_WIDTH-1:EXT_WIDTH];
              2'h1: accum_middle_word[sel_alt] <= opnd_x_i[RF_WIDTH-1:EXT_WIDTH];
              default: accum_high_word[sel_alt] <= opnd_x_i[EXT_WIDTH+HIGH_WIDTH-1:EXT_WIDTH];
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // Register file write port.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rf_we_o      <= 1'b0;
      rf_waddr_o   <= '0;
      rf_wdata_o   <= '0;
      bad_select_o <= 1'b0;
    end else begin
      rf_we_o      <= 1'b0;
      bad_select_o <= do_op && (op_i == MAO_OP_MOVE) && !sel_legal;
      if (do_op) begin
        unique case (op_i)
          MAO_OP_ROUND: begin
            if (!to_acc_i) begin
              rf_we_o    <= 1'b1;
              rf_waddr_o <= dest_data_reg_i;
              rf_wdata_o <= format_modifier_i[1] ? to_rf(rnd_res[63:32])
                                                 : to_rf(rnd_res[31:0]);
            end
          end
          MAO_OP_MOVE: begin
            if (!mv_dir && sel_legal) begin
              rf_we_o    <= 1'b1;
              rf_waddr_o <= data_reg_select;
              unique case (sel_part)
                2'h0:    rf_wdata_o <= to_rf(accum_low_word[sel_alt]);
                2'h1:    rf_wdata_o <= to_rf(accum_middle_word[sel_alt]);
                default: rf_wdata_o <= to_rf({{16{accum_high_word[sel_alt][15]}},
                                              accum_high_word[sel_alt]});
              endcase
            end
          end
          MAO_OP_FMUL: begin
            rf_we_o    <= 1'b1;
            rf_waddr_o <= dest_data_reg_i;
            rf_wdata_o <= fm_prod;
          end
          default: ;
        endcase
      end
    end
  end

  // Status flags.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      {product_negative_flag_o, product_overflow_flag_o,
       product_underflow_flag_o, product_invalid_flag_o} <= FLAGS_RESET;
    end else if (do_op) begin
      unique case (op_i)
        MAO_OP_ROUND: begin
          product_negative_flag_o  <= rnd_res[ACC_WIDTH-1];
          product_overflow_flag_o  <= rnd_ovf;
          product_underflow_flag_o <= rnd_unf;
        end
        MAO_OP_FMUL: begin
          product_negative_flag_o  <= fm_neg;
          product_overflow_flag_o  <= fm_ovf;
          product_underflow_flag_o <= fm_unf;
          product_invalid_flag_o   <= fm_inv;
        end
        MAO_OP_MOVE: begin
          if (sel_legal) begin
            {product_negative_flag_o, product_overflow_flag_o,
             product_underflow_flag_o, product_invalid_flag_o} <= 4'h0;
          end
        end
        default: ;
      endcase
    end
  end

  assign accum_primary_o   = {accum_high_word[0], accum_middle_word[0], accum_low_word[0]};
  assign accum_alternate_o = {accum_high_word[1], accum_middle_word[1], accum_low_word[1]};

endmodule : mao_core

// *** sim/mao_chk.sv ***
/* Assertions on the ports of mao_core.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module mao_chk
  import mao_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  input wire logic                  op_valid_i,
  input wire mao_op_t               op_i,
  input wire logic                  acc_alt_i,
  input wire logic                  to_acc_i,
  input wire logic [MV_FIELD_W-1:0] move_field_i,
  input wire logic [RSEL_WIDTH-1:0] dest_data_reg_i,
  input wire logic [RF_WIDTH-1:0]   opnd_x_i,
  input wire logic                  rf_we_o,
  input wire logic [RSEL_WIDTH-1:0] rf_waddr_o,
  input wire logic [RF_WIDTH-1:0]   rf_wdata_o,
  input wire logic                  bad_select_o,
  input wire logic                  product_negative_flag_o,
  input wire logic                  product_overflow_flag_o,
  input wire logic                  product_underflow_flag_o,
  input wire logic                  product_invalid_flag_o,
  input wire logic [ACC_WIDTH-1:0]  accum_primary_o,
  input wire logic [ACC_WIDTH-1:0]  accum_alternate_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] flg;
  logic       rnd;
  logic       mv;
  logic [3:0] sel;
  assign flg = {product_negative_flag_o, product_overflow_flag_o,
                product_underflow_flag_o, product_invalid_flag_o};
  assign rnd = op_valid_i && op_i == MAO_OP_ROUND;
  assign mv  = op_valid_i && op_i == MAO_OP_MOVE;
  assign sel = move_field_i[MV_SEL_LSB+:4];
  property p_round_reg;
    rnd && !to_acc_i |=> rf_we_o && rf_wdata_o[7:0] == 8'h00
      && rf_waddr_o == $past(dest_data_reg_i);
  endproperty
  a_round_reg: assert property (p_round_reg) else $error("round write wrong");
  property p_round_acc;
    rnd && to_acc_i && acc_alt_i |=> !rf_we_o && accum_alternate_o[31:0] == 32'h0
      && accum_primary_o == $past(accum_primary_o);
  endproperty
  a_round_acc: assert property (p_round_acc) else $error("round acc wrong");
  property p_round_inv;
    rnd |=> product_invalid_flag_o == $past(product_invalid_flag_o);
  endproperty
  a_round_inv: assert property (p_round_inv) else $error("round changed invalid");
  property p_clear;
    op_valid_i && op_i == MAO_OP_CLEAR && acc_alt_i |=> accum_alternate_o == '0
      && flg == $past(flg) && accum_primary_o == $past(accum_primary_o);
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");
  property p_move_in;
    mv && move_field_i[MV_DIR_POS] && sel == SEL_ALT_MID |=> !rf_we_o && flg == 4'h0
      && accum_alternate_o[63:32] == $past(opnd_x_i[39:8]);
  endproperty
  a_move_in: assert property (p_move_in) else $error("move in wrong");
  property p_move_out;
    mv && !move_field_i[MV_DIR_POS] && sel == SEL_PRI_MID |=> rf_we_o
      && rf_wdata_o == {$past(accum_primary_o[63:32]), 8'h00}
      && rf_waddr_o == $past(move_field_i[MV_REG_LSB+:4]);
  endproperty
  a_move_out: assert property (p_move_out) else $error("move out wrong");
  property p_bad_sel;
    mv && (sel[3] || sel[1:0] == 2'h3) |=> bad_select_o && !rf_we_o ##1 !bad_select_o;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad select not refused");
  property p_fmul;
    op_valid_i && op_i == MAO_OP_FMUL |=> rf_we_o && rf_waddr_o == $past(dest_data_reg_i);
  endproperty
  a_fmul: assert property (p_fmul) else $error("product not written");
  c_round: cover property (rnd && to_acc_i);
  c_move: cover property (mv ##1 mv);
  c_inv: cover property ($rose(product_invalid_flag_o));
endmodule : mao_chk
bind mao_core mao_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i),
  .op_i(op_i), .acc_alt_i(acc_alt_i), .to_acc_i(to_acc_i), .move_field_i(move_field_i),
  .dest_data_reg_i(dest_data_reg_i), .opnd_x_i(opnd_x_i), .rf_we_o(rf_we_o),
  .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o), .bad_select_o(bad_select_o),
  .product_negative_flag_o(product_negative_flag_o),
  .product_overflow_flag_o(product_overflow_flag_o),
  .product_underflow_flag_o(product_underflow_flag_o),
  .product_invalid_flag_o(product_invalid_flag_o),
  .accum_primary_o(accum_primary_o), .accum_alternate_o(accum_alternate_o));

// *** sim/mao_rf_model.sv ***
/* Register file standing beside the block; it stores every write.
   Assumes writes arrive as one-cycle strobes on the core clock. */
`timescale 1ns/1ps
module mao_rf_model
  import mao_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  we_i,
  input  wire logic [RSEL_WIDTH-1:0] waddr_i,
  input  wire logic [RF_WIDTH-1:0]   wdata_i,
  input  wire logic [RSEL_WIDTH-1:0] raddr_i,
  output logic      [RF_WIDTH-1:0]   rdata_o
);
  logic [RF_WIDTH-1:0] regs [16];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      regs[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = regs[raddr_i];
endmodule : mao_rf_model

// *** sim/tb_top.sv ***
/* Self-checking bench for mao_core with a queue of expected writes.
   Assumes a 20 MHz clock and results one cycle after each operation. */
`timescale 1ns/1ps
module tb_top
  import mao_pkg::*;
;
  typedef struct {logic [3:0] a; logic [39:0] d; logic [3:0] f; logic [3:0] m;} mao_note_t;
  logic clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, acc_alt_i = 1'b0, to_acc_i = 1'b0;
  mao_op_t op_i = MAO_OP_NONE;
  logic [1:0] format_modifier_i = 2'h0;
  logic [22:0] move_field_i = '0;
  logic [3:0] dest_data_reg_i = 4'h0, rf_waddr_o, flg;
  logic [39:0] opnd_x_i = '0, opnd_y_i = '0, rf_wdata_o, rd;
  logic rf_we_o, bad_select_o, fn, fv, fu, fi;
  logic [79:0] accum_primary_o, accum_alternate_o;
  logic [31:0] seed, w[6], e;
  logic [3:0] sel[6] = '{SEL_PRI_LOW, SEL_PRI_MID, SEL_PRI_HIGH, SEL_ALT_LOW, SEL_ALT_MID,
    SEL_ALT_HIGH};
  mao_note_t notes[$], n;
  int failures = 0, n_checks = 0, i;
  always #25 clk_i = ~clk_i;
  assign flg = {fn, fv, fu, fi};
  mao_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .acc_alt_i(acc_alt_i), .to_acc_i(to_acc_i), .format_modifier_i(format_modifier_i),
    .move_field_i(move_field_i), .dest_data_reg_i(dest_data_reg_i), .opnd_x_i(opnd_x_i),
    .opnd_y_i(opnd_y_i), .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o),
    .bad_select_o(bad_select_o), .product_negative_flag_o(fn), .product_overflow_flag_o(fv),
    .product_underflow_flag_o(fu), .product_invalid_flag_o(fi),
    .accum_primary_o(accum_primary_o), .accum_alternate_o(accum_alternate_o));
  mao_rf_model u_rf (.clk_i(clk_i), .we_i(rf_we_o), .waddr_i(rf_waddr_o),
    .wdata_i(rf_wdata_o), .raddr_i(4'h2), .rdata_o(rd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [22:0] mf(input logic dir, input logic [3:0] s, input logic [3:0] r);
    return {10'h0, dir, s, r, 4'h0};
  endfunction : mf
  task automatic miss(input string s);
    failures++;
    $display("MISMATCH %0t %s", $time, s);
  endtask : miss
  task automatic chk(input logic [79:0] g, input logic [79:0] x);
    n_checks++;
    if (g !== x) miss("accumulator value");
  endtask : chk
  task automatic exp(input logic [3:0] a, input logic [39:0] d, input logic [3:0] f,
                     input logic [3:0] m);
    notes.push_back('{a, d, f, m});
  endtask : exp
  task automatic issue(input mao_op_t op, input logic alt, input logic ta, input logic [1:0] fm,
                       input logic [22:0] mv, input logic [3:0] r, input logic [39:0] x,
                       input logic [39:0] y);
    op_valid_i <= 1'b1;
    op_i <= op;
    acc_alt_i <= alt;
    to_acc_i <= ta;
    format_modifier_i <= fm;
    move_field_i <= mv;
    dest_data_reg_i <= r;
    opnd_x_i <= x;
    opnd_y_i <= y;
    @(posedge clk_i);
  endtask : issue
  task automatic idle(input int c);
    op_valid_i <= 1'b0;
    repeat (c) @(posedge clk_i);
  endtask : idle
  task automatic ld(input logic alt, input logic [31:0] h, input logic [31:0] m,
                    input logic [31:0] l);
    issue(MAO_OP_MOVE, 0, 0, 0, mf(1, {1'b0, alt, 2'h2}, 0), 0, {h, 8'hFF}, 0);
    issue(MAO_OP_MOVE, 0, 0, 0, mf(1, {1'b0, alt, 2'h1}, 0), 0, {m, 8'hFF}, 0);
    issue(MAO_OP_MOVE, 0, 0, 0, mf(1, {1'b0, alt, 2'h0}, 0), 0, {l, 8'hFF}, 0);
  endtask : ld
  task automatic fm(input logic [39:0] x, input logic [39:0] y, input logic [39:0] d,
                    input logic [3:0] f, input logic [3:0] m);
    exp(4'h7, d, f, m);
    issue(MAO_OP_FMUL, 0, 0, 0, 0, 4'h7, x, y);
  endtask : fm
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  always @(posedge clk_i) begin
    if (nrst_i && rf_we_o === 1'b1) begin
      if (notes.size() == 0) begin
        miss("unexpected register write");
      end else begin
        n = notes.pop_front();
        n_checks++;
        if (rf_waddr_o !== n.a || rf_wdata_o !== n.d || (flg & n.m) !== (n.f & n.m))
          miss("register write or flags");
      end
    end
  end
  initial begin
    seed = 32'h945D7E04;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      w[i] = seed;
      issue(MAO_OP_MOVE, 0, 0, 0, mf(1, sel[i], 0), 0, {seed, 8'hA5}, 0);
    end
    for (i = 0; i < 6; i++) begin
      e = (i % 3 == 2) ? {{16{w[i][15]}}, w[i][15:0]} : w[i];
      exp(i[3:0], {e, 8'h00}, 4'h0, 4'hF);
      issue(MAO_OP_MOVE, 0, 0, 0, mf(0, sel[i], i[3:0]), 0, 40'h0, 0);
    end
    issue(MAO_OP_MOVE, 0, 0, 0, mf(0, 4'h3, 4'h1), 0, 0, 0);
    idle(1);
    chk(accum_primary_o, {w[2][15:0], w[1], w[0]});
    chk(accum_alternate_o, {w[5][15:0], w[4], w[3]});
    chk({40'h0, rd}, {40'h0, {{16{w[2][15]}}, w[2][15:0]}, 8'h00});
    ld(0, 0, 32'h12345678, 32'h80000000);
    exp(4'h5, {32'h12345679, 8'h00}, 4'b0100, 4'hF);
    issue(MAO_OP_ROUND, 0, 0, FMT_SF, 0, 4'h5, 0, 0);
    exp(4'h6, 40'h0, 4'b0100, 4'hF);
    issue(MAO_OP_ROUND, 0, 0, FMT_UI, 0, 4'h6, 0, 0);
    ld(1, 32'h0000FFFF, 32'hFFFFFFFF, 32'h7FFFFFFF);
    fm({1'b0, 8'hFF, 31'h1}, {1'b0, 8'h7F, 31'h0}, 40'h7FFFFFFFFF, 4'b0001, 4'h7);
    exp(4'h8, {32'hFFFFFFFF, 8'h00}, 4'b1001, 4'hF);
    issue(MAO_OP_ROUND, 1, 0, FMT_SF, 0, 4'h8, 0, 0);
    exp(4'h9, 40'h0, 4'b1101, 4'hF);
    issue(MAO_OP_ROUND, 1, 0, FMT_SI, 0, 4'h9, 0, 0);
    exp(4'hA, {32'hFFFFFFFF, 8'h00}, 4'b1101, 4'hF);
    issue(MAO_OP_ROUND, 1, 0, FMT_UF, 0, 4'hA, 0, 0);
    issue(MAO_OP_ROUND, 1, 1, FMT_SF, 0, 4'h0, 0, 0);
    idle(1);
    chk(accum_alternate_o, 80'hFFFF_FFFFFFFF_00000000);
    chk(accum_primary_o, {16'h0, 32'h12345678, 32'h80000000});
    issue(MAO_OP_CLEAR, 1, 0, 0, 0, 0, 0, 0);
    idle(1);
    chk(accum_alternate_o, 80'h0);
    fm({1'b0, 8'h7F, 31'h40000000}, {1'b0, 8'h80, 31'h0}, {1'b0, 8'h80, 31'h40000000},
       4'b0000, 4'hF);
    fm({1'b1, 8'h7F, 31'h40000000}, {1'b0, 8'h80, 31'h0}, {1'b1, 8'h80, 31'h40000000},
       4'b1000, 4'hF);
    fm({1'b0, 8'hFE, 31'h0}, {1'b0, 8'h80, 31'h0}, {1'b0, 8'hFF, 31'h0}, 4'b0100, 4'hF);
    fm({1'b0, 8'h01, 31'h0}, {1'b0, 8'h7E, 31'h0}, 40'h0, 4'b0010, 4'hF);
    fm({1'b0, 8'hFF, 31'h0}, 40'h0, 40'h7FFFFFFFFF, 4'b0001, 4'h7);
    idle(1);
    for (i = 0; i < 20 && notes.size() != 0; i++) @(posedge clk_i);
    if (notes.size() != 0) miss("expected write never came");
    results();
  end
endmodule : tb_top
